/* File: hdl/can_mode_regs.vh */
// Register offsets, field positions and timing counts for the CAN mode and filter routing block.
// Assumes a plain register port with 16-bit data; included by the block's design file.
`ifndef CAN_MODE_REGS_VH
`define CAN_MODE_REGS_VH
`define ADDR_W 4
`define DATA_W 16
`define OFF_CTRL1 4'h0
`define OFF_BUFPNT4 4'h1
`define OFF_STATUS 4'h2
`define REQ_HI 10
`define REQ_LO 8
`define REP_HI 7
`define REP_LO 5
`define F15_HI 15
`define F15_LO 12
`define F14_HI 11
`define F14_LO 8
`define F13_HI 7
`define F13_LO 4
`define F12_HI 3
`define F12_LO 0
`define PTR_FIFO 4'hf
`define IDLE_BITS 4'hb
`define MODE_RESET 3'h4
`define CTRL1_RESET 16'h0480
`define CTRL1_KEEP 16'hf81f
`define BUFPNT4_RESET 16'h0000
`endif

/* File: hdl/can_mode_and_filter_routing.v */
// Operating-mode request/confirm logic and filter 12-15 buffer routing of a CAN controller.
// Assumes the bit-timing logic gives a one-cycle sample pulse with the sampled bus level,
// and that the acceptance logic gives a one-cycle hit pulse with the filter number.
// Notes on behaviour
// - Six operating modes, chosen by software.
// - Mode request field at control bits 10:8.
// - Mode in force reported at bits 7:5.
// - Hold current mode until bus allows switch.
// - Bus idle after eleven consecutive recessive bits.
// - Filter 15 pointer bits 15-12; 1111 selects FIFO.
// - Pointer 0000-1110 selects that receive buffer.
// - Filters 14,13,12 pointers at 11-8,7-4,3-0.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "can_mode_regs.vh"
module can_mode_and_filter_routing (
  input wire SYS_CLK,
  input wire RESETN,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`DATA_W-1:0] RDATA,
  input wire BIT_SAMPLE,
  input wire RX_LEVEL,
  input wire HIT_VALID,
  input wire [1:0] HIT_FILTER,
  output reg STORE_VALID,
  output reg STORE_FIFO,
  output reg [3:0] STORE_BUFFER,
  output wire [2:0] ACTIVE_MODE
);
  reg [2:0] req_r;
  reg [2:0] mode_r;
  reg [15:0] ctrl_other_r;
  reg [15:0] bufpnt_r;
  reg [3:0] recessive_cnt_r;
  wire rx_sync;
  wire samp_sync;
  reg samp_prev_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] mode_nxt;
  reg store_fifo_nxt;
  reg [3:0] store_buf_nxt;

  // Switch control: in step with the request, or waiting for an idle bus
  localparam ST_HOLD = 2'b01;
  localparam ST_PEND = 2'b10;
  wire bus_idle;
  wire samp_edge;
  reg [3:0] sel_ptr;

  assign ACTIVE_MODE = mode_r;
  // Any of the eight mode codes is accepted; unused codes simply pass through
  assign bus_idle = (recessive_cnt_r >= `IDLE_BITS);
  // Sample pulse arrives from the bit-timing domain, so it is synchronised and edge-detected
  assign samp_edge = samp_sync & ~samp_prev_r;

  // Bus level resets recessive so no false dominant bit follows reset
  sync2 #(
    .RESET_VAL(1'b1)
  ) rx_sync_i (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .d(RX_LEVEL),
    .q(rx_sync)
  );

  sync2 #(
    .RESET_VAL(1'b0)
  ) samp_sync_i (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .d(BIT_SAMPLE),
    .q(samp_sync)
  );

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      samp_prev_r <= 1'b0;
    end else begin
      samp_prev_r <= samp_sync;
    end
  end

  // Saturating counter: wrap-around would falsely drop the idle indication on a long idle bus
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      recessive_cnt_r <= 4'h0;
    end else if (samp_edge) begin
      if (!rx_sync) begin
        recessive_cnt_r <= 4'h0;
      end else if (!bus_idle) begin
        recessive_cnt_r <= recessive_cnt_r + 4'h1;
      end
    end
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_r <= `MODE_RESET;
      mode_r <= `MODE_RESET;
      state_r <= ST_HOLD;
      ctrl_other_r <= 16'h0000;
      bufpnt_r <= `BUFPNT4_RESET;
    end else begin
      if (WR && ADDR == `OFF_CTRL1) begin
        req_r <= WDATA[`REQ_HI:`REQ_LO];
        ctrl_other_r <= WDATA & `CTRL1_KEEP;
      end
      if (WR && ADDR == `OFF_BUFPNT4) begin
        bufpnt_r <= WDATA;
      end
      mode_r <= mode_nxt;
      state_r <= state_nxt;
    end
  end

  // A request that arrives while the bus is busy is parked, never dropped
  always @* begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    case (state_r)
      ST_HOLD: begin
        if (req_r != mode_r) begin
          if (bus_idle) begin
            mode_nxt = req_r;
          end else begin
            state_nxt = ST_PEND;
          end
        end
      end
      ST_PEND: begin
        if (req_r == mode_r) begin
          state_nxt = ST_HOLD;
        end else if (bus_idle) begin
          mode_nxt = req_r;
          state_nxt = ST_HOLD;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  always @* begin
    case (HIT_FILTER)
      2'h3: sel_ptr = bufpnt_r[`F15_HI:`F15_LO];
      2'h2: sel_ptr = bufpnt_r[`F14_HI:`F14_LO];
      2'h1: sel_ptr = bufpnt_r[`F13_HI:`F13_LO];
      default: sel_ptr = bufpnt_r[`F12_HI:`F12_LO];
    endcase
  end

  // Buffer index reads zero for FIFO hits so software never sees a stale index
  always @* begin
    store_fifo_nxt = 1'b0;
    store_buf_nxt = sel_ptr;
    if (sel_ptr == `PTR_FIFO) begin
      store_fifo_nxt = HIT_VALID;
      store_buf_nxt = 4'h0;
    end
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      STORE_VALID <= 1'b0;
      STORE_FIFO <= 1'b0;
      STORE_BUFFER <= 4'h0;
    end else begin
      STORE_VALID <= HIT_VALID;
      STORE_FIFO <= store_fifo_nxt;
      STORE_BUFFER <= store_buf_nxt;
    end
  end

  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        `OFF_CTRL1: RDATA <= (ctrl_other_r & `CTRL1_KEEP) | {5'h00, req_r, mode_r, 5'h00};
        `OFF_BUFPNT4: RDATA <= bufpnt_r;
        `OFF_STATUS: RDATA <= {11'h000, bus_idle, recessive_cnt_r};
        default: RDATA <= 16'h0000;
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end
endmodule // can_mode_and_filter_routing

// Two-stage synchroniser; only the second stage may be read
module sync2 #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  input wire clk,
  input wire rst_n,
  input wire d,
  output wire q
);
  reg meta_r;
  reg sync_r;

  assign q = sync_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end
endmodule // sync2

/* File: tb/rt_sva.sv */
// Checker on the routing block ports
// Sees top ports only; bound below
`timescale 1ns/1ps
module rt_sva(input wire SYS_CLK, RESETN, WR, RD, HIT_VALID, STORE_VALID, STORE_FIFO, RX_LEVEL,
  input wire [3:0] ADDR, STORE_BUFFER, input wire [15:0] WDATA, RDATA, input wire [1:0] HIT_FILTER,
  input wire [2:0] ACTIVE_MODE);
  reg [15:0] p_r;
  reg [2:0] q_r;
  wire [15:0] s = p_r >> {HIT_FILTER, 2'h0};
  wire [3:0] n = s[3:0];
  // Shadows of what software wrote
  always @(posedge SYS_CLK or negedge RESETN)
    if (!RESETN) begin
      p_r <= 16'h0000;
      q_r <= 3'h4;
    end else if (WR) begin
      if (ADDR == 4'h1) p_r <= WDATA;
      if (ADDR == 4'h0) q_r <= WDATA[10:8];
    end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_hit_store: assert property (HIT_VALID |=> STORE_VALID) else $error("no store");
  a_no_hit: assert property (!HIT_VALID |=> !STORE_VALID) else $error("stray store");
  a_route_target: assert property (HIT_VALID |=> STORE_FIFO == ($past(n) == 4'hf) &&
    (STORE_FIFO || STORE_BUFFER == $past(n))) else $error("bad target");
  a_mode_idle: assert property ($changed(ACTIVE_MODE) |-> $past(RX_LEVEL, 3)) else $error("busy switch");
  a_mode_req: assert property ($changed(ACTIVE_MODE) |-> ACTIVE_MODE == $past(q_r)) else $error("bad mode");
  a_ptr_read: assert property (RD && ADDR == 4'h1 |=> RDATA == p_r) else $error("bad ptr");
  a_ctrl_read: assert property (RD && ADDR == 4'h0 |=> RDATA[10:5] == {q_r, $past(ACTIVE_MODE)})
    else $error("bad ctrl");
  a_unmapped_zero: assert property (RD && ADDR > 4'h2 |=> RDATA == 16'h0000) else $error("bad hole");
  cover property (HIT_VALID && HIT_FILTER == 2'h3);
  cover property ($changed(ACTIVE_MODE));
  cover property (RD && ADDR == 4'h1);
endmodule // rt_sva
bind can_mode_and_filter_routing rt_sva chk_i(.*);

/* File: tb/can_node.sv */
// Bus node model: bit pulses and bus level
// Sample every four clocks keeps idle waits short
`timescale 1ns/1ps
module can_node(input wire SYS_CLK, dom, output wire BIT_SAMPLE, RX_LEVEL);
  reg [1:0] c_r = 2'h0;
  always @(posedge SYS_CLK) c_r <= c_r + 2'h1;
  assign BIT_SAMPLE = c_r[1];
  assign RX_LEVEL = !dom;
endmodule // can_node

/* File: tb/can_mode_and_filter_routing_tb_top.sv */
// Bench for mode and routing block
// Node model drives the bus side
`timescale 1ns/1ps
module can_mode_and_filter_routing_tb_top;
  reg SYS_CLK = 1'h0, RESETN = 1'h0, WR = 1'h0, RD = 1'h0, HIT_VALID = 1'h0, dom = 1'h0;
  reg [3:0] ADDR = 4'h0;
  reg [15:0] WDATA = 16'h0000, e;
  reg [1:0] HIT_FILTER = 2'h0;
  wire [15:0] RDATA;
  wire STORE_VALID, STORE_FIFO, BIT_SAMPLE, RX_LEVEL;
  wire [3:0] STORE_BUFFER;
  wire [2:0] ACTIVE_MODE;
  integer err_total = 0, n_checks = 0, cyc = 0, i;
  always #10 SYS_CLK = ~SYS_CLK;
  can_node node(.SYS_CLK(SYS_CLK), .dom(dom), .BIT_SAMPLE(BIT_SAMPLE), .RX_LEVEL(RX_LEVEL));
  can_mode_and_filter_routing dut(.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .BIT_SAMPLE(BIT_SAMPLE), .RX_LEVEL(RX_LEVEL), .HIT_VALID(HIT_VALID),
    .HIT_FILTER(HIT_FILTER), .STORE_VALID(STORE_VALID), .STORE_FIFO(STORE_FIFO),
    .STORE_BUFFER(STORE_BUFFER), .ACTIVE_MODE(ACTIVE_MODE));
  task chk(input [15:0] g, input [15:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("Error %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge SYS_CLK) {WR, ADDR, WDATA} <= {1'h1, a, d};
      @(posedge SYS_CLK) WR <= 1'h0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] x);
    begin
      @(posedge SYS_CLK) {RD, ADDR} <= {1'h1, a};
      @(posedge SYS_CLK) RD <= 1'h0;
      #1 chk(RDATA, x);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge SYS_CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  task t_route;
    begin
      wr(4'h1, 16'hfe01);
      rd(4'h1, 16'hfe01);
      for (i = 0; i < 4; i = i + 1) begin
        e = 16'hfe01 >> (4 * i);
        @(posedge SYS_CLK) {HIT_VALID, HIT_FILTER} <= {1'h1, i[1:0]};
        @(posedge SYS_CLK) HIT_VALID <= 1'h0;
        #1 chk({STORE_VALID, STORE_FIFO, STORE_BUFFER}, e[3:0] == 4'hf ? 16'h0030 : {11'h001, 1'h0, e[3:0]});
        @(posedge SYS_CLK) #1 chk(STORE_VALID, 16'h0000);
      end
      $display("routing test done");
    end
  endtask
  task t_mode;
    begin
      dom <= 1'h1;
      repeat (20) @(posedge SYS_CLK);
      wr(4'h0, 16'h0200);
      wr(4'h0, 16'h0300);
      repeat (60) @(posedge SYS_CLK);
      chk(ACTIVE_MODE, 16'h0004);
      dom <= 1'h0;
      repeat (32) @(posedge SYS_CLK);
      chk(ACTIVE_MODE, 16'h0004);
      repeat (40) @(posedge SYS_CLK);
      rd(4'h0, 16'h0360);
      for (i = 0; i < 6; i = i + 1) begin
        wr(4'h0, {5'h00, i[2:0], 8'h00});
        repeat (4) @(posedge SYS_CLK);
        chk(ACTIVE_MODE, i[2:0]);
      end
      $display("mode test done");
    end
  endtask
  task t_rst;
    begin
      @(posedge SYS_CLK) RESETN <= 1'h0;
      repeat (3) @(posedge SYS_CLK);
      RESETN <= 1'h1;
      #1 chk(ACTIVE_MODE, 16'h0004);
      rd(4'h0, 16'h0480);
      rd(4'h1, 16'h0000);
      $display("reset test done");
    end
  endtask
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RESETN <= 1'h1;
    rd(4'h0, 16'h0480);
    rd(4'hf, 16'h0000);
    t_route;
    t_mode;
    t_rst;
    end_sim;
  end
endmodule // can_mode_and_filter_routing_tb_top
